// ==== inc/sms_defines.vh ====
`ifndef SMS_DEFINES_VH
`define SMS_DEFINES_VH
// register indices (word addresses on the plain port)
`define SMS_ADDR_CTRL     4'h0
`define SMS_ADDR_CMD      4'h1
`define SMS_ADDR_TARGET   4'h2
`define SMS_ADDR_POS      4'h3
`define SMS_ADDR_LIM_MIN  4'h4
`define SMS_ADDR_LIM_MAX  4'h5
`define SMS_ADDR_VSTART   4'h6
`define SMS_ADDR_VRUN     4'h7
`define SMS_ADDR_ACCEL    4'h8
`define SMS_ADDR_DECEL    4'h9
`define SMS_ADDR_LOOP     4'ha
`define SMS_ADDR_STATUS   4'hb
`define SMS_ADDR_IRQ_STAT 4'hc
`define SMS_ADDR_IRQ_EN   4'hd
`define SMS_ADDR_IRQ_CLR  4'he
`define SMS_ADDR_SCALE    4'hf
// command codes written to CMD
`define SMS_CMD_ABS       3'h1
`define SMS_CMD_CONT      3'h2
`define SMS_CMD_PAUSE     3'h3
`define SMS_CMD_STOP      3'h4
`define SMS_CMD_SHORTSTOP 3'h5
`define SMS_CMD_ESC       3'h6
`define SMS_CMD_LOOP_END  3'h7
// ctrl bits
`define SMS_CTRL_PROG     0
`define SMS_CTRL_LOOP_INF 1
`define SMS_CTRL_LOOP_ON  2
// irq bits
`define SMS_IRQ_DONE      0
`define SMS_IRQ_LIMIT     1
`define SMS_IRQ_EOT       2
`define SMS_IRQ_LOOP      3
// limits
`define SMS_ABS_MAX       32'sd999999999
`define SMS_SCALE_DIV     32'd1000
// velocity accumulator: step when phase wraps 2^32
`define SMS_VEL_RESET     32'h0000_0000
`endif

// ==== src/sms_sequencer.v ====
// What this block does
// [R1] compare position against signed min/max limits
// [R2] equal limits disable limit checking
// [R3] limit reached: stop at once, flag error
// [R4] limits scaled like position by distance scale
// [R5] counted repeat runs body n times
// [R6] uncounted repeat runs until stop/limit
// [R7] absolute move: distance is target minus position
// [R8] integer targets, or thousandths when scaled
// [R9] continuous move ramps start to run velocity
// [R10] continuous move holds velocity, accepts commands
// [R11] pause/stop/esc/limits end continuous move
// [R12] immediate mode: new params on next continuous
// [R13] program mode: continue past continuous move
// [R14] host may load the position counter
// [R15] zero-distance absolute move completes without steps
// [R16] pause/stop decelerates to start velocity
`timescale 1ns/1ps
`include "sms_defines.vh"
module sms_sequencer (
    input wire clk_in,
    input wire rst_in,
    input wire [3:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire eot_limit_in,
    output reg [31:0] rdata_out,
    output reg step_out,
    output reg dir_out,
    output reg busy_out,
    output reg next_stmt_out,
    output reg irq_out
);
    localparam S_IDLE = 2'h0;
    localparam S_ACC = 2'h1;
    localparam S_RUN = 2'h2;
    localparam S_DEC = 2'h3;

    reg [1:0] state;
    reg cont_mode;
    reg [2:0] ctrl;
    reg [15:0] scale;
    reg signed [31:0] target;
    reg signed [31:0] pos;
    reg signed [31:0] lim_min;
    reg signed [31:0] lim_max;
    reg [31:0] vstart;
    reg [31:0] vrun;
    reg [31:0] accel;
    reg [31:0] decel;
    reg [31:0] act_vrun;
    reg [31:0] act_accel;
    reg [31:0] act_decel;
    reg [31:0] vel;
    reg [31:0] phase;
    reg [31:0] remain;
    reg [15:0] loop_cnt;
    reg [15:0] loop_load;
    reg [3:0] irq_stat;
    reg [3:0] irq_en;
    reg lim_err;

    wire [31:0] tgt_steps_u;
    wire [31:0] lim_min_u;
    wire [31:0] lim_max_u;
    wire at_max;
    wire at_min;

    // absolute target in steps; scaled targets carry thousandths
    // one scaler per value keeps target and limits in the same units
    sms_scale tgt_scale (
        .value_in(target),
        .scale_in(scale),
        .steps_out(tgt_steps_u)
    ); // [R8] [R4]
    sms_scale lim_min_scale (
        .value_in(lim_min),
        .scale_in(scale),
        .steps_out(lim_min_u)
    ); // [R4]
    sms_scale lim_max_scale (
        .value_in(lim_max),
        .scale_in(scale),
        .steps_out(lim_max_u)
    ); // [R4]
    wire signed [31:0] tgt_steps = tgt_steps_u;
    wire signed [31:0] delta = tgt_steps - pos; // [R7]
    wire lim_on = (lim_min != lim_max); // [R2]
    sms_lim_cmp #(.UPPER(1)) max_cmp (
        .pos_in(pos),
        .lim_in(lim_max_u),
        .past_out(at_max)
    ); // [R1]
    sms_lim_cmp #(.UPPER(0)) min_cmp (
        .pos_in(pos),
        .lim_in(lim_min_u),
        .past_out(at_min)
    ); // [R1]
    wire lim_hit = lim_on && state != S_IDLE &&
        ((dir_out && at_max) || (!dir_out && at_min)); // [R1]
    wire cmd_wr = wr_in && addr_in == `SMS_ADDR_CMD;
    wire [2:0] cmd = wdata_in[2:0];
    wire stop_cmd = cmd_wr && (cmd == `SMS_CMD_PAUSE || cmd == `SMS_CMD_STOP);
    wire hard_cmd = cmd_wr && (cmd == `SMS_CMD_SHORTSTOP || cmd == `SMS_CMD_ESC);
    wire [32:0] next_phase = {1'b0, phase} + {1'b0, vel};
    // no pulse once a limit or the distance is used up, so nothing overshoots
    wire step_now = next_phase[32] && state != S_IDLE && !lim_hit &&
        !eot_limit_in && (cont_mode || remain != 32'd0); // [R3]
    wire [3:0] ev;
    wire loop_done_ev;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= S_IDLE;
            cont_mode <= 1'b0;
            ctrl <= 3'h0;
            scale <= 16'h0000;
            target <= 32'sh0;
            pos <= 32'sh0;
            lim_min <= 32'sh0;
            lim_max <= 32'sh0;
            vstart <= 32'h0;
            vrun <= 32'h0;
            accel <= 32'h0;
            decel <= 32'h0;
            act_vrun <= 32'h0;
            act_accel <= 32'h0;
            act_decel <= 32'h0;
            vel <= `SMS_VEL_RESET;
            phase <= 32'h0;
            remain <= 32'h0;
            step_out <= 1'b0;
            dir_out <= 1'b0;
            busy_out <= 1'b0;
            next_stmt_out <= 1'b0;
            lim_err <= 1'b0;
        end else begin
            step_out <= step_now;
            next_stmt_out <= 1'b0;
            lim_err <= 1'b0;
            if (wr_in) begin
                case (addr_in)
                    `SMS_ADDR_CTRL: ctrl <= wdata_in[2:0];
                    `SMS_ADDR_TARGET: target <= wdata_in;
                    `SMS_ADDR_LIM_MIN: lim_min <= wdata_in;
                    `SMS_ADDR_LIM_MAX: lim_max <= wdata_in;
                    `SMS_ADDR_VSTART: vstart <= wdata_in;
                    `SMS_ADDR_VRUN: vrun <= wdata_in;
                    `SMS_ADDR_ACCEL: accel <= wdata_in;
                    `SMS_ADDR_DECEL: decel <= wdata_in;
                    `SMS_ADDR_SCALE: scale <= wdata_in[15:0];
                    default: ;
                endcase
            end
            // position load only while stopped, avoids racing the step count
            if (wr_in && addr_in == `SMS_ADDR_POS && state == S_IDLE) begin
                pos <= wdata_in; // [R14]
            end else if (step_now) begin
                pos <= dir_out ? pos + 32'sd1 : pos - 32'sd1;
            end
            phase <= (state == S_IDLE) ? 32'h0 : next_phase[31:0];
            if (step_now && !cont_mode) begin
                remain <= remain - 32'd1;
            end
            case (state)
                S_IDLE: begin
                    if (cmd_wr && cmd == `SMS_CMD_ABS) begin
                        if (delta == 32'sh0) begin
                            next_stmt_out <= 1'b1; // [R15]
                        end else begin
                            dir_out <= ~delta[31]; // [R7]
                            remain <= delta[31] ? 32'd0 - delta : delta;
                            cont_mode <= 1'b0;
                            act_vrun <= vrun;
                            act_accel <= accel;
                            act_decel <= decel;
                            vel <= vstart;
                            busy_out <= 1'b1;
                            state <= S_ACC;
                        end
                    end else if (cmd_wr && cmd == `SMS_CMD_CONT) begin
                        // run velocity, accel and decel latched here, so their later writes wait for next start; vstart is read live in deceleration
                        act_vrun <= vrun; // [R12]
                        act_accel <= accel;
                        act_decel <= decel;
                        dir_out <= wdata_in[31];
                        cont_mode <= 1'b1;
                        vel <= vstart; // [R9]
                        busy_out <= 1'b1;
                        state <= S_ACC;
                        next_stmt_out <= ctrl[`SMS_CTRL_PROG]; // [R13]
                    end
                end
                S_ACC, S_RUN, S_DEC: begin
                    if (lim_hit || eot_limit_in || hard_cmd) begin
                        state <= S_IDLE; // [R3] [R11]
                        vel <= 32'h0;
                        busy_out <= 1'b0;
                        lim_err <= lim_hit;
                    end else if (state != S_DEC && (stop_cmd ||
                            (!cont_mode && remain <= 32'd2))) begin
                        state <= S_DEC; // [R16] [R11]
                    end else if (state == S_ACC) begin
                        if (vel + act_accel >= act_vrun) begin
                            vel <= act_vrun;
                            state <= S_RUN; // [R9]
                        end else begin
                            vel <= vel + act_accel;
                        end
                    end else if (state == S_DEC) begin
                        if ((!cont_mode && remain == 32'd0) ||
                                vel <= vstart + act_decel) begin
                            vel <= vstart; // [R16]
                            if (!cont_mode && remain != 32'd0) begin
                                state <= S_DEC;
                            end else begin
                                state <= S_IDLE;
                                busy_out <= 1'b0;
                                next_stmt_out <= ~cont_mode | ~ctrl[`SMS_CTRL_PROG];
                            end
                        end else begin
                            vel <= vel - act_decel;
                        end
                    end
                    // run state just holds act_vrun; host commands still taken
                    // [R10]
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // repeat block counter; count 0 ends at the first loop end like count 1, infinite until stop or limit
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            loop_cnt <= 16'h0;
            loop_load <= 16'h0;
        end else if (wr_in && addr_in == `SMS_ADDR_LOOP) begin
            loop_load <= wdata_in[15:0];
            loop_cnt <= wdata_in[15:0]; // [R5]
        end else if (cmd_wr && cmd == `SMS_CMD_LOOP_END && loop_cnt != 16'h0 &&
                !ctrl[`SMS_CTRL_LOOP_INF]) begin
            loop_cnt <= loop_cnt - 16'h1; // [R5]
        end else if (ctrl[`SMS_CTRL_LOOP_INF] && (stop_cmd || hard_cmd || lim_err ||
                eot_limit_in)) begin
            loop_cnt <= 16'h0; // [R6]
        end
    end
    // repeat again while counting down past one, or forever when uncounted
    wire loop_again = ctrl[`SMS_CTRL_LOOP_ON] && (ctrl[`SMS_CTRL_LOOP_INF] ?
        !(stop_cmd || hard_cmd || lim_err || eot_limit_in) : loop_cnt > 16'h1); // [R6]
    assign loop_done_ev = cmd_wr && cmd == `SMS_CMD_LOOP_END && !loop_again;
    wire ev_done = next_stmt_out;
    wire ev_limit = lim_err;
    // switch counts only while moving; a parked axis on its switch is no event
    wire ev_eot = eot_limit_in & busy_out;
    assign ev = {loop_done_ev, ev_eot, ev_limit, ev_done};

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_stat <= 4'h0;
            irq_en <= 4'h0;
            irq_out <= 1'b0;
        end else begin
            if (wr_in && addr_in == `SMS_ADDR_IRQ_EN) begin
                irq_en <= wdata_in[3:0];
            end
            // set beats clear in the same cycle
            irq_stat <= (irq_stat & ~((wr_in && addr_in == `SMS_ADDR_IRQ_CLR) ?
                wdata_in[3:0] : 4'h0)) | ev;
            irq_out <= |(irq_stat & irq_en);
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 32'h0;
        end else if (rd_in) begin
            case (addr_in)
                `SMS_ADDR_CTRL: rdata_out <= {29'h0, ctrl};
                `SMS_ADDR_TARGET: rdata_out <= target;
                `SMS_ADDR_POS: rdata_out <= pos;
                `SMS_ADDR_LIM_MIN: rdata_out <= lim_min;
                `SMS_ADDR_LIM_MAX: rdata_out <= lim_max;
                `SMS_ADDR_VSTART: rdata_out <= vstart;
                `SMS_ADDR_VRUN: rdata_out <= vrun;
                `SMS_ADDR_ACCEL: rdata_out <= accel;
                `SMS_ADDR_DECEL: rdata_out <= decel;
                `SMS_ADDR_LOOP: rdata_out <= {loop_load, loop_cnt};
                `SMS_ADDR_STATUS: rdata_out <= {25'h0, loop_again, lim_on, cont_mode,
                    dir_out, busy_out, state};
                `SMS_ADDR_IRQ_STAT: rdata_out <= {28'h0, irq_stat};
                `SMS_ADDR_IRQ_EN: rdata_out <= {28'h0, irq_en};
                `SMS_ADDR_SCALE: rdata_out <= {16'h0, scale};
                default: rdata_out <= 32'h0;
            endcase
        end else begin
            rdata_out <= 32'h0;
        end
    end
endmodule

// scales a signed value to steps; 64-bit product so large values cannot wrap
module sms_scale (
    input wire [31:0] value_in,
    input wire [15:0] scale_in,
    output wire [31:0] steps_out
);
    wire signed [63:0] value_x = {{32{value_in[31]}}, value_in};
    wire signed [63:0] scale_x = {48'h0, scale_in};
    wire signed [63:0] div_x = {32'h0, `SMS_SCALE_DIV};
    wire signed [63:0] prod = value_x * scale_x;
    wire signed [63:0] quot = prod / div_x;
    // zero scale means plain integer steps, no rounding at all
    assign steps_out = (scale_in == 16'h0000) ? value_in : quot[31:0];
endmodule

// equality counts as reached, so the last step lands on the limit
module sms_lim_cmp #(
    parameter UPPER = 1
) (
    input wire signed [31:0] pos_in,
    input wire signed [31:0] lim_in,
    output wire past_out
);
    assign past_out = UPPER ? (pos_in >= lim_in) : (pos_in <= lim_in);
endmodule

// ==== bench/sms_sequencer_checker.sv ====
`timescale 1ns/1ps
`include "sms_defines.vh"
module sms_sequencer_checker (
    input wire clk_in,
    input wire rst_in,
    input wire [3:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire eot_limit_in,
    input wire [31:0] rdata_out,
    input wire step_out,
    input wire dir_out,
    input wire busy_out,
    input wire next_stmt_out,
    input wire irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire cmd_wr = wr_in && addr_in == `SMS_ADDR_CMD;
    wire [2:0] code = wdata_in[2:0];
    property p_rd_idle; !rd_in |=> rdata_out == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    property p_step_pulse; step_out |=> !step_out; endproperty
    a_step_pulse: assert property (p_step_pulse) else $error("step pulse too long");
    property p_ns_pulse; next_stmt_out |=> !next_stmt_out; endproperty
    a_ns_pulse: assert property (p_ns_pulse) else $error("advance pulse too long");
    property p_dir_hold; busy_out && $past(busy_out) |-> $stable(dir_out); endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("direction changed in move");
    property p_idle_nostep; !busy_out [*2] |-> !step_out; endproperty
    a_idle_nostep: assert property (p_idle_nostep) else $error("step while idle");
    property p_quick; cmd_wr && (code == `SMS_CMD_SHORTSTOP || code == `SMS_CMD_ESC)
        |-> ##[1:3] !busy_out; endproperty
    a_quick: assert property (p_quick) else $error("instant stop too slow");
    property p_ramp; cmd_wr && (code == `SMS_CMD_PAUSE || code == `SMS_CMD_STOP) && busy_out
        |-> ##1 busy_out [*2]; endproperty
    a_ramp: assert property (p_ramp) else $error("no ramp down");
    property p_eot; eot_limit_in |-> ##[1:3] !busy_out; endproperty
    a_eot: assert property (p_eot) else $error("switch did not stop");
    property p_eot_step; eot_limit_in [*3] |-> !step_out; endproperty
    a_eot_step: assert property (p_eot_step) else $error("step at switch");
endmodule

// ==== bench/sms_drv_model.sv ====
`timescale 1ns/1ps
module sms_drv_model (
    input wire clk_in,
    input wire rst_in,
    input wire step_in,
    input wire dir_in,
    output logic [31:0] pos_out
);
    // counts pulses only; a real driver never answers back
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pos_out <= 32'h0;
        end else if (step_in) begin
            pos_out <= dir_in ? pos_out + 32'h1 : pos_out - 32'h1;
        end
    end
endmodule

// ==== bench/tb_stepper_motion_sequencer.sv ====
`timescale 1ns/1ps
`include "sms_defines.vh"
module tb_stepper_motion_sequencer;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [3:0] addr_in = 4'h0;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic eot_limit_in = 1'b0;
    wire [31:0] rdata_out;
    wire step_out, dir_out, busy_out, next_stmt_out, irq_out;
    wire [31:0] pos;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    int ns_cnt = 0;
    logic [31:0] rv, base;
    int n0;
    always #2.5 clk_in = ~clk_in;
    sms_sequencer uut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .eot_limit_in(eot_limit_in),
        .rdata_out(rdata_out), .step_out(step_out), .dir_out(dir_out), .busy_out(busy_out),
        .next_stmt_out(next_stmt_out), .irq_out(irq_out));
    sms_drv_model drv (.clk_in(clk_in), .rst_in(rst_in), .step_in(step_out),
        .dir_in(dir_out), .pos_out(pos));
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (next_stmt_out === 1'b1) ns_cnt <= ns_cnt + 1;
        if (cyc == 60000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 rv = rdata_out;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // bounded wait: a stuck busy shows as a mismatch, not a hang
    task automatic idle(input int n);
        tick(2);
        for (int i = 0; i < n && busy_out !== 1'b0; i++) tick(1);
        chk({31'h0, busy_out}, 32'h0);
    endtask
    task automatic vel(input logic [31:0] vs, input logic [31:0] vr);
        wr(`SMS_ADDR_VSTART, vs);
        wr(`SMS_ADDR_VRUN, vr);
        wr(`SMS_ADDR_ACCEL, 32'h0010_0000);
        wr(`SMS_ADDR_DECEL, 32'h0010_0000);
    endtask
    task automatic t_abs();
        chk({30'h0, busy_out, irq_out}, 32'h0);
        wr(`SMS_ADDR_POS, 32'hc465_3601);
        rd(`SMS_ADDR_POS);
        chk(rv, 32'hc465_3601);
        wr(`SMS_ADDR_POS, 32'h0);
        vel(32'h4000_0000, 32'h4000_0000);
        base = pos;
        n0 = ns_cnt;
        wr(`SMS_ADDR_TARGET, 32'hffff_fffb);
        wr(`SMS_ADDR_CMD, {29'h0, `SMS_CMD_ABS});
        idle(300);
        chk(pos - base, 32'hffff_fffb);
        rd(`SMS_ADDR_POS);
        chk(rv, 32'hffff_fffb);
        base = pos;
        wr(`SMS_ADDR_CMD, {29'h0, `SMS_CMD_ABS});
        tick(6);
        chk(pos - base, 32'h0);
        chk(ns_cnt - n0, 32'h2);
        wr(`SMS_ADDR_SCALE, 32'h1f4);
        wr(`SMS_ADDR_TARGET, 32'ha);
        base = pos;
        wr(`SMS_ADDR_CMD, {29'h0, `SMS_CMD_ABS});
        idle(300);
        chk(pos - base, 32'ha);
        rd(`SMS_ADDR_POS);
        chk(rv, 32'h5);
        wr(`SMS_ADDR_SCALE, 32'h0);
        $display("test abs done");
    endtask
    task automatic t_limit();
        wr(`SMS_ADDR_IRQ_CLR, 32'hf);
        wr(`SMS_ADDR_LIM_MIN, 32'hffff_ff9c);
        wr(`SMS_ADDR_LIM_MAX, 32'h3);
        wr(`SMS_ADDR_POS, 32'h0);
        base = pos;
        wr(`SMS_ADDR_CMD, {29'h0, `SMS_CMD_CONT} | 32'h8000_0000);
        idle(400);
        chk(pos - base, 32'h3);
        rd(`SMS_ADDR_IRQ_STAT);
        chk({31'h0, rv[`SMS_IRQ_LIMIT]}, 32'h1);
        wr(`SMS_ADDR_IRQ_EN, 32'h0);
        tick(2);
        chk({31'h0, irq_out}, 32'h0);
        wr(`SMS_ADDR_IRQ_EN, 32'h2);
        tick(2);
        chk({31'h0, irq_out}, 32'h1);
        wr(`SMS_ADDR_IRQ_CLR, 32'h2);
        tick(2);
        chk({31'h0, irq_out}, 32'h0);
        $display("test limit done");
    endtask
    task automatic t_stops();
        logic [2:0] codes [4] = '{`SMS_CMD_PAUSE, `SMS_CMD_STOP, `SMS_CMD_SHORTSTOP,
            `SMS_CMD_ESC};
        wr(`SMS_ADDR_LIM_MIN, 32'h5);
        wr(`SMS_ADDR_LIM_MAX, 32'h5);
        wr(`SMS_ADDR_CTRL, 32'h1);
        vel(32'h1000_0000, 32'h4000_0000);
        foreach (codes[k]) begin
            base = pos;
            n0 = ns_cnt;
            wr(`SMS_ADDR_CMD, {29'h0, `SMS_CMD_CONT} | 32'h8000_0000);
            tick(100);
            chk(ns_cnt - n0, 32'h1);
            chk({31'h0, busy_out && (pos - base > 32'h5)}, 32'h1);
            wr(`SMS_ADDR_CMD, {29'h0, codes[k]});
            idle(1500);
        end
        wr(`SMS_ADDR_CTRL, 32'h0);
        base = pos;
        wr(`SMS_ADDR_CMD, {29'h0, `SMS_CMD_CONT});
        tick(20);
        @(posedge clk_in);
        eot_limit_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        eot_limit_in <= 1'b0;
        tick(1);
        chk({31'h0, busy_out}, 32'h0);
        rd(`SMS_ADDR_IRQ_STAT);
        chk({31'h0, rv[`SMS_IRQ_EOT]}, 32'h1);
        $display("test stops done");
    endtask
    task automatic t_loop();
        wr(`SMS_ADDR_IRQ_CLR, 32'hf);
        wr(`SMS_ADDR_LOOP, 32'h2);
        wr(`SMS_ADDR_CTRL, 32'h4);
        wr(`SMS_ADDR_CMD, {29'h0, `SMS_CMD_LOOP_END});
        rd(`SMS_ADDR_IRQ_STAT);
        chk({31'h0, rv[`SMS_IRQ_LOOP]}, 32'h0);
        wr(`SMS_ADDR_CMD, {29'h0, `SMS_CMD_LOOP_END});
        rd(`SMS_ADDR_IRQ_STAT);
        chk({31'h0, rv[`SMS_IRQ_LOOP]}, 32'h1);
        wr(`SMS_ADDR_IRQ_CLR, 32'hf);
        wr(`SMS_ADDR_CTRL, 32'h6);
        repeat (3) wr(`SMS_ADDR_CMD, {29'h0, `SMS_CMD_LOOP_END});
        rd(`SMS_ADDR_IRQ_STAT);
        chk({31'h0, rv[`SMS_IRQ_LOOP]}, 32'h0);
        $display("test loop done");
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        t_abs();
        t_limit();
        t_stops();
        t_loop();
        tally_and_finish();
    end
endmodule
bind sms_sequencer sms_sequencer_checker chk_i (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .eot_limit_in(eot_limit_in), .rdata_out(rdata_out), .step_out(step_out),
    .dir_out(dir_out), .busy_out(busy_out), .next_stmt_out(next_stmt_out), .irq_out(irq_out));
